// ===== hw/ccoc_consts.svh
// Constants of the capture/compare output-stage control block.
`ifndef CCOC_CONSTS_SVH
`define CCOC_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave.
`define CCOC_CTRL_OFS 32'h0000_0000
`define CCOC_STAT_OFS 32'h0000_0004
`define CCOC_ADDR_MSB 11

// Control register field positions.
`define CCOC_ONESHOT_EXTEND_COUNT_MSB 14
`define CCOC_ONESHOT_EXTEND_COUNT_LSB 12
`define CCOC_OUTPUT_STEER_SELECT_MSB 10
`define CCOC_OUTPUT_STEER_SELECT_LSB 8
`define CCOC_POL1_BIT 5
`define CCOC_POL2_BIT 4

// Reset value and writable bits of the control register.
`define CCOC_CTRL_RST 16'h0000
`define CCOC_CTRL_WMASK 16'h7730

// Output steering codes.
`define CCOC_MODE_SINGLE 3'h0
`define CCOC_MODE_PUSHPULL 3'h1
`define CCOC_MODE_HALFBRIDGE 3'h2
`define CCOC_MODE_RSVD_A 3'h3
`define CCOC_MODE_BDC_REV 3'h4
`define CCOC_MODE_BDC_FWD 3'h5
`define CCOC_MODE_SCAN 3'h6
`define CCOC_MODE_RSVD_B 3'h7

// Last index of the scan sequence.
`define CCOC_SCAN_LAST 3'h5

`endif

// ===== hw/ccoc_pkg.sv
// Types shared by the output-stage control block.
package ccoc_pkg;

  // Six output pins, pin a in the top bit.
  typedef struct packed {
    logic out_pin_a;
    logic out_pin_b;
    logic out_pin_c;
    logic out_pin_d;
    logic out_pin_e;
    logic out_pin_f;
  } ccoc_pins_s;

  // Control register fields as they sit in the word.
  typedef struct packed {
    logic rsvd_15;
    logic [2:0] oneshot_extend_count;
    logic rsvd_11;
    logic [2:0] output_steer_select;
    logic [1:0] rsvd_7_6;
    logic polarity_group_one;
    logic polarity_group_two;
    logic [3:0] rsvd_3_0;
  } ccoc_ctrl_s;

  typedef logic [2:0] ccoc_count_t;

endpackage

// ===== hw/ccoc_top.sv
// Output-stage control of a capture/compare/PWM unit with an AHB-Lite slave.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccoc_consts.svh"
// Function
// - Nonzero count stretches one-shot N extra periods.
// - Zero count leaves one-shot one period.
// - Bits 11 and 7:6 read zero.
// - Mode codes 011 and 111 reserved.
// - Code 101 forward, 100 reverse brush DC.
// - Codes 000 single, 001 push-pull, 010 half-bridge.
// - Code 110 scans waveform across pins.
// - Bit 5 sets polarity of pins A,C,E.
// - Bit 4 sets polarity of pins B,D,F.
module ccoc_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic tb_period_i,
  input wire logic oneshot_trig_i,
  input wire logic pwm_i,
  output logic oneshot_active_o,
  output ccoc_pkg::ccoc_pins_s pins_o
);
  import ccoc_pkg::*;

  // ************************************************************
  // Register bus
  // ************************************************************

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [31:0] hrdata_r;
  logic ph_wr_r;
  logic ph_ctrl_r;
  logic ph_rd_r;
  logic os_active_r;
  ccoc_count_t os_left_r;
  logic [2:0] scan_idx_r;
  logic pp_phase_r;
  logic [5:0] pins_r;

  wire logic acc = hsel_i & htrans_i[1] & hready_i;
  wire logic sel_ctrl = (haddr_i[`CCOC_ADDR_MSB:0] == 12'(`CCOC_CTRL_OFS));
  wire logic sel_stat = (haddr_i[`CCOC_ADDR_MSB:0] == 12'(`CCOC_STAT_OFS));
  wire logic ctrl_wen = ph_wr_r & ph_ctrl_r;
  // Unwritable bits are masked on the way in, so reserved bits stay zero.
  wire logic [15:0] ctrl_wdata = hwdata_i[15:0] & `CCOC_CTRL_WMASK;
  wire ccoc_ctrl_s ctrl = ctrl_r;
  wire ccoc_count_t os_count = ctrl.oneshot_extend_count;
  wire logic [2:0] mode = ctrl.output_steer_select;
  wire logic pol1 = ctrl.polarity_group_one;
  wire logic pol2 = ctrl.polarity_group_two;
  wire logic [15:0] stat_word = {8'h00, pp_phase_r, scan_idx_r, os_active_r, os_left_r};

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wen) begin
      ctrl_nxt = ctrl_wdata;
    end
  end

  // A read right behind a write sees the new value through ctrl_nxt.
  wire logic [31:0] rd_word = sel_ctrl ? {16'h0000, ctrl_nxt} :
                              sel_stat ? {16'h0000, stat_word} : 32'h0000_0000;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `CCOC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_ctrl_r <= 1'b0;
    end else if (hready_i) begin
      ph_wr_r <= acc & hwrite_i;
      ph_rd_r <= acc & ~hwrite_i;
      ph_ctrl_r <= sel_ctrl;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_r <= 32'h0000_0000;
    end else if (acc & ~hwrite_i) begin
      hrdata_r <= rd_word;
    end
  end

  // The slave never stalls and never errors.
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;

  // ************************************************************
  // One-shot stretch
  // ************************************************************

  // A new trigger restarts the stretch even while one is running.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      os_active_r <= 1'b0;
      os_left_r <= 3'h0;
    end else if (oneshot_trig_i) begin
      os_active_r <= 1'b1;
      os_left_r <= os_count;
    end else if (os_active_r & tb_period_i) begin
      if (os_left_r == 3'h0) begin
        os_active_r <= 1'b0;
      end else begin
        os_left_r <= os_left_r - 3'h1;
      end
    end
  end

  assign oneshot_active_o = os_active_r;

  // ************************************************************
  // Steering sequencers
  // ************************************************************

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scan_idx_r <= 3'h0;
      pp_phase_r <= 1'b0;
    end else if (tb_period_i) begin
      pp_phase_r <= ~pp_phase_r;
      scan_idx_r <= (scan_idx_r == `CCOC_SCAN_LAST) ? 3'h0 : scan_idx_r + 3'h1;
    end
  end

  // ************************************************************
  // Steering and polarity
  // ************************************************************

  // Bit 5 is pin a, bit 0 is pin f.
  logic [5:0] raw_scan;
  genvar k;
  generate
    for (k = 0; k < 6; k++) begin : g_scan
      assign raw_scan[5-k] = pwm_i & (scan_idx_r == 3'(k));
    end
  endgenerate

  wire logic [5:0] raw_single = {pwm_i, 5'h00};
  wire logic [5:0] raw_pp = {pwm_i & ~pp_phase_r, pwm_i & pp_phase_r, 4'h0};
  wire logic [5:0] raw_hb = {pwm_i, ~pwm_i, 4'h0};
  // Forward holds pin a on and chops pin d; reverse holds c and chops b.
  wire logic [5:0] raw_fwd = {1'b1, 2'b00, pwm_i, 2'b00};
  wire logic [5:0] raw_rev = {1'b0, pwm_i, 1'b1, 3'b000};
  wire logic [5:0] pol_vec = {pol1, pol2, pol1, pol2, pol1, pol2};

  logic [5:0] raw;
  always_comb begin
    unique case (mode)
      `CCOC_MODE_SINGLE: raw = raw_single;
      `CCOC_MODE_PUSHPULL: raw = raw_pp;
      `CCOC_MODE_HALFBRIDGE: raw = raw_hb;
      `CCOC_MODE_BDC_FWD: raw = raw_fwd;
      `CCOC_MODE_BDC_REV: raw = raw_rev;
      `CCOC_MODE_SCAN: raw = raw_scan;
      // Reserved codes park every pin at its inactive level.
      `CCOC_MODE_RSVD_A: raw = 6'h00;
      `CCOC_MODE_RSVD_B: raw = 6'h00;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_r <= 6'h00;
    end else begin
      pins_r <= raw ^ pol_vec;
    end
  end

  assign pins_o = pins_r;

  // ************************************************************
  // Assertions
  // ************************************************************

  sequence s_trig_n;
    oneshot_trig_i && (os_count != 3'h0);
  endsequence

  sequence s_loaded;
    os_active_r && (os_left_r == $past(os_count));
  endsequence

  AST_OS_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
    s_trig_n |=> s_loaded)
    else $error("one-shot did not load its extend count");

  AST_OS_STEP: assert property (@(posedge clock_i) disable iff (rst_i)
    (os_active_r && tb_period_i && !oneshot_trig_i && os_left_r != 3'h0)
    |=> os_active_r && (os_left_r == $past(os_left_r) - 3'h1))
    else $error("one-shot did not count down one period");

  AST_OS_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
    (os_active_r && (os_left_r == 3'h0) && tb_period_i && !oneshot_trig_i) |=> !os_active_r)
    else $error("one-shot ran past its last period");

  AST_RSVD_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (ph_rd_r && ph_ctrl_r) |-> (hrdata_o[11] == 1'b0) && (hrdata_o[7:6] == 2'b00))
    else $error("unimplemented control bits read nonzero");

  AST_RSVD_MODE: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_RSVD_A || mode == `CCOC_MODE_RSVD_B)
    |=> pins_o == $past(pol_vec))
    else $error("reserved mode drove a pin active");

  AST_BDC_FWD: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_BDC_FWD)
    |=> (pins_o.out_pin_a != $past(pol1)) && (pins_o.out_pin_d == ($past(pwm_i) ^ $past(pol2))))
    else $error("brush DC forward pins wrong");

  AST_BDC_REV: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_BDC_REV)
    |=> (pins_o.out_pin_c != $past(pol1)) && (pins_o.out_pin_b == ($past(pwm_i) ^ $past(pol2))))
    else $error("brush DC reverse pins wrong");

  AST_HALF_BRIDGE: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_HALFBRIDGE)
    |=> (pins_o.out_pin_a ^ $past(pol1)) != (pins_o.out_pin_b ^ $past(pol2)))
    else $error("half-bridge pins not complementary");

  AST_PUSH_PULL: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_PUSHPULL)
    |=> !((pins_o.out_pin_a ^ $past(pol1)) && (pins_o.out_pin_b ^ $past(pol2))))
    else $error("push-pull drove both pins active");

  AST_SCAN_ONE: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_SCAN) |=> $onehot0(pins_o ^ $past(pol_vec)))
    else $error("scan mode drove more than one pin");

  AST_POL_ACE: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_SINGLE) |=>
    (pins_o.out_pin_c == $past(pol1)) && (pins_o.out_pin_e == $past(pol1)))
    else $error("idle level of pins c and e ignores polarity");

  AST_POL_BDF: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_SINGLE) |=> (pins_o.out_pin_b == $past(pol2)) &&
    (pins_o.out_pin_d == $past(pol2)) && (pins_o.out_pin_f == $past(pol2)))
    else $error("idle level of pins b, d and f ignores polarity");

  AST_POL_ORDER: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode == `CCOC_MODE_SINGLE) |=> pins_o.out_pin_a == ($past(pwm_i) ^ $past(pol1)))
    else $error("pin a is not the steered waveform at its polarity");

  // ************************************************************
  // Sequencer and register guards
  // ************************************************************

  // The scan index must walk pins a to f and then start over; a stuck
  // index would leave one pin carrying the waveform for good.
  sequence s_scan_adv;
    tb_period_i && (scan_idx_r != `CCOC_SCAN_LAST);
  endsequence

  sequence s_scan_end;
    tb_period_i && (scan_idx_r == `CCOC_SCAN_LAST);
  endsequence

  AST_SCAN_STEP: assert property (@(posedge clock_i) disable iff (rst_i)
    s_scan_adv |=> scan_idx_r == $past(scan_idx_r) + 3'h1)
    else $error("scan index did not advance");

  AST_SCAN_WRAP: assert property (@(posedge clock_i) disable iff (rst_i)
    s_scan_end |=> scan_idx_r == 3'h0)
    else $error("scan index did not wrap to pin a");

  AST_PP_ALTERNATE: assert property (@(posedge clock_i) disable iff (rst_i)
    tb_period_i |=> pp_phase_r != $past(pp_phase_r))
    else $error("push-pull phase did not alternate");

  // A zero count still arms the one-shot for its own period.
  AST_OS_ZERO_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
    (oneshot_trig_i && (os_count == 3'h0)) |=> os_active_r && (os_left_r == 3'h0))
    else $error("one-shot with zero count did not arm for one period");

  AST_OS_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    (os_active_r && !tb_period_i && !oneshot_trig_i) |=> os_active_r && $stable(os_left_r))
    else $error("one-shot count moved without a period end");

  AST_OS_IDLE: assert property (@(posedge clock_i) disable iff (rst_i)
    (!os_active_r && !oneshot_trig_i) |=> !os_active_r)
    else $error("one-shot started without a trigger");

  AST_CTRL_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    ctrl_wen |=> ctrl_r == $past(ctrl_wdata))
    else $error("control write did not land masked");

  AST_RSVD_HELD: assert property (@(posedge clock_i) disable iff (rst_i)
    (ctrl_r[11] == 1'b0) && (ctrl_r[7:6] == 2'b00))
    else $error("unimplemented control bits hold a one");

endmodule // ccoc_top
`default_nettype wire

// ===== tb/ccoc_stage_model.sv
// Power stage model that turns pin levels back into switch-on states.
`timescale 1ns/10ps
`default_nettype none
module ccoc_stage_model (
  input wire ccoc_pkg::ccoc_pins_s pins_i,
  input wire logic pol_one_i,
  input wire logic pol_two_i,
  output logic [5:0] on_o
);
  import ccoc_pkg::*;
  // The stage is wired for the active level of each pin group, so a wrong level shows here.
  assign on_o = pins_i ^ {3{pol_one_i, pol_two_i}};
endmodule // ccoc_stage_model
`default_nettype wire

// ===== tb/tb.sv
// Testbench of the output-stage control block.
`timescale 1ns/10ps
`default_nettype none
`include "ccoc_consts.svh"
module tb;
  import ccoc_pkg::*;
  logic clock, rst, hsel, hwrite, tbp, trig, pwm, hready, hresp, act, p1, p2;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  ccoc_pins_s pins;
  logic [5:0] on;
  int n_mismatch, n_checks, n;
  ccoc_top DUT (.clock_i(clock), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .tb_period_i(tbp), .oneshot_trig_i(trig), .pwm_i(pwm), .oneshot_active_o(act),
    .pins_o(pins));
  ccoc_stage_model stage (.pins_i(pins), .pol_one_i(p1), .pol_two_i(p2), .on_o(on));
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // ****************************************
  // Bus, stimulus and compare tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hready !== 1'h1 && i < 16);
    if (hready !== 1'h1) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  function automatic logic [31:0] ctrl(input logic [2:0] c, input logic [2:0] m);
    return {17'h0, c, 1'h0, m, 2'h0, p1, p2, 4'h0};
  endfunction
  function automatic logic [5:0] steer(input logic [2:0] m, input logic p, input int k,
                                        input logic ph);
    logic [5:0] r;
    r = 6'h00;
    case (m)
      `CCOC_MODE_SINGLE: r[5] = p;
      `CCOC_MODE_PUSHPULL: r[5:4] = {p & ~ph, p & ph};
      `CCOC_MODE_HALFBRIDGE: r[5:4] = {p, ~p};
      `CCOC_MODE_BDC_FWD: r = {1'h1, 2'h0, p, 2'h0};
      `CCOC_MODE_BDC_REV: r = {1'h0, p, 1'h1, 3'h0};
      `CCOC_MODE_SCAN: r[5 - k] = p;
      default: r = 6'h00;
    endcase
    return r;
  endfunction
  task automatic look(input logic [2:0] m, input int k, input logic ph);
    logic [5:0] r;
    r = steer(m, pwm, k, ph);
    @(negedge clock);
    chk("pins", {26'h0, r ^ {3{p1, p2}}}, {26'h0, pins});
    chk("stage", {26'h0, r}, {26'h0, on});
  endtask
  task automatic pulse();
    @(posedge clock);
    tbp <= 1'h1;
    @(posedge clock);
    tbp <= 1'h0;
    @(posedge clock);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, hsel, hsize} = 5'h1A;
    {hwrite, htrans, haddr, hwdata} = 67'h0;
    {tbp, trig, pwm, p1, p2} = 5'h00;
    {n_mismatch, n_checks} = 64'h0;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    bus(1'h0, `CCOC_CTRL_OFS, 32'h0);
    chk("ctrl reset", {16'h0, `CCOC_CTRL_RST}, rd);
    bus(1'h1, `CCOC_CTRL_OFS, 32'hFFFF_FFFF);
    bus(1'h0, `CCOC_CTRL_OFS, 32'h0);
    chk("ctrl bits", {16'h0, `CCOC_CTRL_WMASK}, rd);
    bus(1'h0, 32'h0000_0008, 32'h0);
    chk("unmapped", 32'h0, rd);
    // No period pulse is issued here, so scan index and push-pull phase stay at zero.
    for (int m = 0; m < 8; m++) begin
      for (int j = 0; j < 8; j++) begin
        {p1, p2} = j[2:1];
        pwm <= j[0];
        bus(1'h1, `CCOC_CTRL_OFS, ctrl(3'h0, m[2:0]));
        repeat (2) @(posedge clock);
        look(m[2:0], 0, 1'h0);
      end
    end
    {p1, p2} = 2'h0;
    pwm <= 1'h1;
    bus(1'h1, `CCOC_CTRL_OFS, ctrl(3'h0, `CCOC_MODE_SCAN));
    for (int k = 0; k < 8; k++) begin
      repeat (2) @(posedge clock);
      look(`CCOC_MODE_SCAN, k % 6, 1'h0);
      pulse();
    end
    bus(1'h1, `CCOC_CTRL_OFS, ctrl(3'h0, `CCOC_MODE_PUSHPULL));
    repeat (2) @(posedge clock);
    look(`CCOC_MODE_PUSHPULL, 0, 1'h0);
    pulse();
    look(`CCOC_MODE_PUSHPULL, 0, 1'h1);
    for (int c = 0; c < 8; c++) begin
      bus(1'h1, `CCOC_CTRL_OFS, ctrl(c[2:0], `CCOC_MODE_SINGLE));
      @(posedge clock);
      trig <= 1'h1;
      @(posedge clock);
      trig <= 1'h0;
      @(negedge clock);
      chk("active", 32'h1, {31'h0, act});
      bus(1'h0, `CCOC_STAT_OFS, 32'h0);
      chk("left", {28'h0, 1'h1, c[2:0]}, {28'h0, rd[3:0]});
      n = 0;
      while (act === 1'h1 && n < 12) begin
        pulse();
        n++;
        @(negedge clock);
      end
      chk("periods", c + 1, n);
    end
    final_report();
  end
endmodule // tb
`default_nettype wire
